// ==== hw/ata_cmd_consts.vh ====
/*
 Constants for the task-file command decoder: register indices, opcodes,
 field positions, reset values and timing counts. Definitions only.
*/
`ifndef ATA_CMD_CONSTS_VH
`define ATA_CMD_CONSTS_VH

// Parameter register indices
`define IDX_FEATURE 3'h1
`define IDX_COUNT 3'h2
`define IDX_SECTOR 3'h3
`define IDX_TRACK_LO 3'h4
`define IDX_TRACK_HI 3'h5
`define IDX_UNIT 3'h6
`define IDX_COMMAND 3'h7

// Field positions
`define UNIT_DRV_BIT 4
`define UNIT_HEAD_MSB 3
`define DEVCTL_HOB_BIT 7

// Power state answers
`define PWR_STANDBY_ANS 8'h00
`define PWR_IDLE_ANS 8'hFF

// Error register abort bit
`define ERR_ABORT 8'h04
`define ERR_NONE 8'h00

// Opcodes
`define OP_CHK_PWR_A 8'hE5
`define OP_CHK_PWR_B 8'h98
`define OP_VERIFY_A 8'h40
`define OP_VERIFY_B 8'h41
`define OP_VERIFY_EXT 8'h42
`define OP_NATIVE_MAX 8'hF8
`define OP_NATIVE_MAX_EXT 8'h27
`define OP_NOP 8'h00

// Parameter usage classes (flag bits)
`define USE_NONE 4'h0
`define USE_DRV 4'h1
`define USE_DRVHEAD 4'h2
`define USE_LBA 4'h4
`define USE_EXT 4'h8

// Register reset value
`define REG_RESET 8'h00

// Countdown cycles in the execute state before the opcode is acted on
`define BUSY_CYCLES 4'h2
`endif

// ==== hw/param_store.v ====
/*
 Double-write parameter store: one 16-bit slot per task-file index.
 Assumes writes arrive one per cycle, synchronous to the core clock.
*/
`timescale 1ns/1ps
`include "ata_cmd_consts.vh"
module param_store #(
    parameter SLOTS = 8
) (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire wr_i,
    input wire [2:0] wr_idx_i,
    input wire [7:0] wr_data_i,
    input wire ld_i,
    input wire [2:0] ld_idx_i,
    input wire [7:0] ld_data_i,
    input wire [2:0] rd_idx_i,
    input wire rd_hi_i,
    output reg [7:0] rd_data_o,
    output wire [16*SLOTS-1:0] flat_o
);
    genvar g;
    generate
        for (g = 0; g < SLOTS; g = g + 1) begin : slots
            // One register per slot keeps a single driver for each word
            reg [15:0] slot_reg;
            always @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    slot_reg <= {`REG_RESET, `REG_RESET};
                end else if (ld_i && ld_idx_i == g) begin
                    slot_reg <= {slot_reg[7:0], ld_data_i};
                end else if (wr_i && wr_idx_i == g) begin
                    slot_reg <= {slot_reg[7:0], wr_data_i};
                end
            end
            assign flat_o[16*g+15:16*g] = slot_reg;
        end
    endgenerate
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= `REG_RESET;
        end else begin
            rd_data_o <= rd_hi_i ? flat_o[16*rd_idx_i+8 +: 8] : flat_o[16*rd_idx_i +: 8];
        end
    end
endmodule

// ==== hw/ata_command_decoder.v ====
/*
 Task-file command decoder: keeps the parameter registers, decodes an
 opcode when it is written, answers the power mode query itself, hands
 other supported non-legacy commands on, and aborts unknown opcodes.
 Assumes the host interface logic delivers register writes and reads as
 one-cycle strobes on clk_sys_i; the power state comes from the same clock.
*/
// Summary of operation
// - A power query in or around standby sets busy, loads 00h into the count register, clears busy, interrupts.
// - A power query while idle sets busy, loads FFh into the count register, clears busy, interrupts.
// - The power query reads only the drive bit, bit 4 of the unit select register.
// - Each double-written register keeps its two writes as one 16-bit value, first write high.
// - Device control bit 7 chooses whether reads return the high or low byte.
// - Drive-only commands use just the drive bit; full commands use drive and head.
// - Indices are feature 1, count 2, sector 3, track 4 and 5, unit select 6.
// - Opcodes 40h and 41h are 28-bit verify and 42h the 48-bit verify, using count, sector and track.
// - F8h is the 28-bit native maximum query and 27h its 48-bit form, both drive-only.
// - Command-specific registers are passed raw for the command to interpret.
// - Parameters are loaded first; only the opcode write starts a command.
// - Legacy compatibility commands complete as no-operation with status only.
`timescale 1ns/1ps
`include "ata_cmd_consts.vh"
module ata_command_decoder (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire tf_wr_i,
    input wire [2:0] tf_idx_i,
    input wire [7:0] tf_wdata_i,
    input wire tf_rd_i,
    input wire [2:0] tf_rd_idx_i,
    input wire devctl_wr_i,
    input wire [7:0] devctl_wdata_i,
    input wire pwr_standby_i,
    input wire cmd_done_i,
    output wire [7:0] tf_rdata_o,
    output reg busy_o,
    output reg irq_o,
    output reg [7:0] error_o,
    output reg cmd_start_o,
    output reg [7:0] cmd_code_o,
    output reg [3:0] cmd_use_o,
    output reg cmd_drive_o,
    output reg [3:0] cmd_head_o,
    output reg [15:0] cmd_count_o,
    output reg [47:0] cmd_lba_o,
    output reg [15:0] cmd_feature_o
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_EXEC = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [3:0] cnt_reg;
    reg hob_reg;
    reg [7:0] op_reg;
    reg [3:0] use_reg;
    reg ld_reg;
    reg [7:0] ld_data_reg;
    wire [127:0] flat;
    wire [15:0] feat_w = flat[16*1+15:16*1];
    wire [15:0] cnt_w = flat[16*2+15:16*2];
    wire [15:0] sec_w = flat[16*3+15:16*3];
    wire [15:0] tlo_w = flat[16*4+15:16*4];
    wire [15:0] thi_w = flat[16*5+15:16*5];
    wire [7:0] unit_w = flat[16*6+7:16*6];
    wire op_wr = tf_wr_i && (tf_idx_i == `IDX_COMMAND);

    // Class of an opcode; zero means unsupported
    function [3:0] op_class;
        input [7:0] op;
        begin
            casez (op)
                `OP_CHK_PWR_A, `OP_CHK_PWR_B: op_class = `USE_DRV;
                `OP_VERIFY_A, `OP_VERIFY_B: op_class = `USE_DRVHEAD | `USE_LBA;
                `OP_VERIFY_EXT: op_class = `USE_DRV | `USE_LBA | `USE_EXT;
                `OP_NATIVE_MAX: op_class = `USE_DRV;
                // the 48-bit form is flagged extended, still drive-only
                `OP_NATIVE_MAX_EXT: op_class = `USE_DRV | `USE_EXT;
                8'h06, 8'h24, 8'h25, 8'h29, 8'h34, 8'h35, 8'h37, 8'h39: op_class = `USE_DRV | `USE_LBA | `USE_EXT;
                8'h20, 8'h30, 8'h3C, 8'h50, 8'hC4, 8'hC5, 8'hC8, 8'hCA, 8'hCB, 8'hF9, 8'h7?:
                    op_class = `USE_DRVHEAD | `USE_LBA;
                8'h60, 8'h61: op_class = `USE_DRV | `USE_LBA;
                8'h1?, 8'h90, 8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'hB0, 8'hC6, 8'hDE, 8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
                8'hE4, 8'hE6, 8'hE7, 8'hE8, 8'hEA, 8'hEC, 8'hEF, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, `OP_NOP:
                    op_class = `USE_DRV;
                default: op_class = `USE_NONE;
            endcase
        end
    endfunction

    // Legacy commands answered with status alone
    function is_legacy;
        input [7:0] op;
        begin
            is_legacy = (op[7:4] == 4'h1) || (op[7:4] == 4'h7) || (op == 8'h50) || (op == `OP_NOP);
        end
    endfunction

    function is_pwr_query;
        input [7:0] op;
        begin
            is_pwr_query = (op == `OP_CHK_PWR_A) || (op == `OP_CHK_PWR_B);
        end
    endfunction

    // index map lives in the store slots
    param_store #(
        .SLOTS(8)
    ) u_store (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .wr_i(tf_wr_i && !op_wr && !busy_o),
        .wr_idx_i(tf_idx_i),
        .wr_data_i(tf_wdata_i),
        .ld_i(ld_reg),
        .ld_idx_i(`IDX_COUNT),
        .ld_data_i(ld_data_reg),
        .rd_idx_i(tf_rd_idx_i),
        .rd_hi_i(hob_reg),
        .rd_data_o(tf_rdata_o),
        .flat_o(flat)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_wr) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (cnt_reg == 4'h0) begin
                    if (use_reg == `USE_NONE || is_legacy(op_reg) || is_pwr_query(op_reg)) begin
                        state_next = ST_DONE;
                    end else begin
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (cmd_done_i) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            hob_reg <= 1'b0;
            op_reg <= `REG_RESET;
            use_reg <= `USE_NONE;
            ld_reg <= 1'b0;
            ld_data_reg <= `REG_RESET;
            busy_o <= 1'b0;
            irq_o <= 1'b0;
            error_o <= `ERR_NONE;
            cmd_start_o <= 1'b0;
            cmd_code_o <= `REG_RESET;
            cmd_use_o <= `USE_NONE;
            cmd_drive_o <= 1'b0;
            cmd_head_o <= 4'h0;
            cmd_count_o <= 16'h0000;
            cmd_lba_o <= 48'h0000_0000_0000;
            cmd_feature_o <= 16'h0000;
        end else begin
            state_reg <= state_next;
            ld_reg <= 1'b0;
            cmd_start_o <= 1'b0;
            irq_o <= 1'b0;
            if (devctl_wr_i) begin
                hob_reg <= devctl_wdata_i[`DEVCTL_HOB_BIT];
            end
            case (state_reg)
                ST_IDLE: begin
                    if (op_wr) begin
                        busy_o <= 1'b1;
                        op_reg <= tf_wdata_i;
                        use_reg <= op_class(tf_wdata_i);
                        cnt_reg <= `BUSY_CYCLES;
                        error_o <= `ERR_NONE;
                    end
                end
                ST_EXEC: begin
                    if (cnt_reg != 4'h0) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else if (use_reg == `USE_NONE) begin
                        error_o <= `ERR_ABORT;
                    end else if (is_pwr_query(op_reg)) begin
                        cmd_drive_o <= unit_w[`UNIT_DRV_BIT];
                        ld_reg <= 1'b1;
                        ld_data_reg <= pwr_standby_i ? `PWR_STANDBY_ANS : `PWR_IDLE_ANS;
                    end else if (!is_legacy(op_reg)) begin
                        // legacy skips the hand-off; fields passed raw
                        cmd_start_o <= 1'b1;
                        cmd_code_o <= op_reg;
                        cmd_use_o <= use_reg;
                        cmd_feature_o <= feat_w;
                        cmd_drive_o <= unit_w[`UNIT_DRV_BIT];
                        // native max queries fall in drive-only class
                        cmd_head_o <= (use_reg & `USE_DRVHEAD) != 4'h0 ? unit_w[`UNIT_HEAD_MSB:0] : 4'h0;
                        if ((use_reg & `USE_EXT) != 4'h0) begin
                            // 16-bit pairs form the 48-bit address
                            cmd_count_o <= cnt_w;
                            cmd_lba_o <= {thi_w[15:8], tlo_w[15:8], sec_w[15:8], thi_w[7:0], tlo_w[7:0], sec_w[7:0]};
                        end else begin
                            cmd_count_o <= {8'h00, cnt_w[7:0]};
                            cmd_lba_o <= {20'h0_0000, unit_w[3:0], thi_w[7:0], tlo_w[7:0], sec_w[7:0]};
                        end
                    end
                end
                ST_DONE: begin
                    busy_o <= 1'b0;
                    irq_o <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// ==== test/ata_command_decoder_checker.sv ====
/* Port checker for the task-file command decoder.
   Assumes one clock domain and the reset values given at the ports. */
`timescale 1ns/1ps
`include "ata_cmd_consts.vh"
module ata_command_decoder_checker (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic tf_wr_i,
    input wire logic [2:0] tf_idx_i,
    input wire logic [7:0] tf_wdata_i,
    input wire logic busy_o,
    input wire logic irq_o,
    input wire logic [7:0] error_o,
    input wire logic cmd_start_o,
    input wire logic [3:0] cmd_use_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    wire op_ok = tf_wr_i && tf_idx_i == `IDX_COMMAND && !busy_o;
    wire [7:0] op = tf_wdata_i;
    wire is_nop = op == 8'h00 || op == 8'h50 || op[7:4] == 4'h1 || op[7:4] == 4'h7;
    property p_take; op_ok |=> busy_o; endproperty
    property p_pwr; op_ok && (op == 8'hE5 || op == 8'h98) |=> busy_o [*4] ##1 (!busy_o && irq_o); endproperty
    property p_irq; irq_o |=> !irq_o; endproperty
    property p_nop; op_ok && is_nop |=> !cmd_start_o [*4] ##1 (irq_o && error_o == `ERR_NONE); endproperty
    property p_abort; op_ok && op == 8'hFF |-> ##5 irq_o && error_o == `ERR_ABORT; endproperty
    property p_vfy; op_ok && (op == 8'h40 || op == 8'h41) |-> ##4 cmd_start_o && cmd_use_o[1] && !cmd_use_o[3];
    endproperty
    property p_vext; op_ok && op == 8'h42 |-> ##4 cmd_start_o && cmd_use_o[0] && cmd_use_o[3]; endproperty
    property p_nmax; op_ok && (op == 8'hF8 || op == 8'h27) |-> ##4 cmd_start_o && cmd_use_o[0] && !cmd_use_o[1]
        && (cmd_use_o[3] == ($past(tf_wdata_i, 4) == 8'h27)); endproperty
    property p_start; cmd_start_o |-> $past(op_ok, 4); endproperty
    a_take: assert property (p_take) else $error("opcode did not raise busy");
    a_pwr: assert property (p_pwr) else $error("power query timing wrong");
    a_irq: assert property (p_irq) else $error("interrupt longer than a cycle");
    a_nop: assert property (p_nop) else $error("legacy command not completed as no-op");
    a_abort: assert property (p_abort) else $error("unknown opcode not aborted");
    a_vfy: assert property (p_vfy) else $error("verify not handed on");
    a_vext: assert property (p_vext) else $error("extended verify not handed on");
    a_nmax: assert property (p_nmax) else $error("native max query not handed on");
    a_start: assert property (p_start) else $error("start without opcode write");
    c_pwr: cover property (op_ok && op == 8'hE5);
    c_start: cover property (cmd_start_o);
    c_abort: cover property (irq_o && error_o == `ERR_ABORT);
endmodule
bind ata_command_decoder ata_command_decoder_checker u_chk (.clk_sys_i, .arst_n_i, .tf_wr_i, .tf_idx_i,
    .tf_wdata_i, .busy_o, .irq_o, .error_o, .cmd_start_o, .cmd_use_o);

// ==== test/ata_host_model.sv ====
/* Host controller model: task-file writes, byte select and reads.
   Assumes the decoder samples on the rising clock edge. */
`timescale 1ns/1ps
module ata_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] tf_rdata_i,
    output logic tf_wr_o,
    output logic [2:0] tf_idx_o,
    output logic [7:0] tf_wdata_o,
    output logic [2:0] tf_rd_idx_o,
    output logic devctl_wr_o,
    output logic [7:0] devctl_wdata_o
);
    initial begin
        tf_wr_o = 1'b0;
        tf_idx_o = 3'h0;
        tf_wdata_o = 8'h00;
        tf_rd_idx_o = 3'h0;
        devctl_wr_o = 1'b0;
        devctl_wdata_o = 8'h00;
    end
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        @(negedge clk_sys_i);
        tf_wr_o = 1'b1;
        tf_idx_o = idx;
        tf_wdata_o = d;
        @(negedge clk_sys_i);
        // Released lines must not look like the last value
        tf_wr_o = 1'b0;
        tf_idx_o = ~idx;
        tf_wdata_o = ~d;
    endtask
    task automatic wr16(input logic [2:0] idx, input logic [15:0] d);
        wr(idx, d[15:8]);
        wr(idx, d[7:0]);
    endtask
    task automatic rd(input logic [2:0] idx, input logic hob, output logic [7:0] d);
        @(negedge clk_sys_i);
        devctl_wr_o = 1'b1;
        devctl_wdata_o = {hob, 7'h00};
        tf_rd_idx_o = idx;
        @(negedge clk_sys_i);
        devctl_wr_o = 1'b0;
        devctl_wdata_o = {~hob, 7'h7F};
        @(negedge clk_sys_i);
        d = tf_rdata_i;
    endtask
endmodule

// ==== test/ata_command_decoder_tb.sv ====
/* Self-checking bench for the command decoder.
   Assumes the host model drives the task file and the bench plays the engine. */
`timescale 1ns/1ps
`include "ata_cmd_consts.vh"
module ata_command_decoder_tb;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic standby = 1'b0;
    logic done = 1'b0;
    logic tf_wr, dc_wr, busy, irq, start, drive;
    logic [2:0] tf_idx, rd_idx;
    logic [7:0] tf_wdata, dc_wdata, rdata, error, code, rv;
    logic [3:0] use_f, head;
    logic [15:0] count, feature;
    logic [47:0] lba;
    int n_errors = 0;
    int comparisons = 0;
    int i;
    logic [7:0] ops [5] = '{8'h40, 8'h41, 8'h42, 8'hF8, 8'h27};
    logic [7:0] nops [5] = '{8'h00, 8'h1A, 8'h7C, 8'h50, 8'hFF};
    logic [3:0] uses [5] = '{4'h6, 4'h6, 4'hD, 4'h1, 4'h9};
    always #20 clk_sys_i = ~clk_sys_i;
    ata_host_model host (.clk_sys_i, .tf_rdata_i(rdata), .tf_wr_o(tf_wr), .tf_idx_o(tf_idx),
        .tf_wdata_o(tf_wdata), .tf_rd_idx_o(rd_idx), .devctl_wr_o(dc_wr), .devctl_wdata_o(dc_wdata));
    ata_command_decoder dut (.clk_sys_i, .arst_n_i, .tf_wr_i(tf_wr), .tf_idx_i(tf_idx), .tf_wdata_i(tf_wdata),
        .tf_rd_i(1'b0), .tf_rd_idx_i(rd_idx), .devctl_wr_i(dc_wr), .devctl_wdata_i(dc_wdata),
        .pwr_standby_i(standby), .cmd_done_i(done), .tf_rdata_o(rdata), .busy_o(busy), .irq_o(irq),
        .error_o(error), .cmd_start_o(start), .cmd_code_o(code), .cmd_use_o(use_f), .cmd_drive_o(drive),
        .cmd_head_o(head), .cmd_count_o(count), .cmd_lba_o(lba), .cmd_feature_o(feature));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Polls start or interrupt; a missing answer ends the run
    task automatic wait_for(input logic want_start);
        int k;
        for (k = 0; k < 20 && (want_start ? start : irq) !== 1'b1; k++) @(negedge clk_sys_i);
        if ((want_start ? start : irq) !== 1'b1) begin
            n_errors++;
            results();
        end
    endtask
    initial begin
        repeat (8) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        check({busy, irq, error}, 10'h000);
        for (i = 0; i < 4; i++) begin
            standby = i[0];
            host.wr(`IDX_COMMAND, i[1] ? `OP_CHK_PWR_B : `OP_CHK_PWR_A);
            // Stray writes while busy must be dropped
            host.wr(`IDX_COUNT, 8'h77);
            host.wr(`IDX_COMMAND, 8'hFF);
            wait_for(1'b0);
            check(error, `ERR_NONE);
            host.rd(`IDX_COUNT, 1'b0, rv);
            check(rv, i[0] ? `PWR_STANDBY_ANS : `PWR_IDLE_ANS);
        end
        for (i = 1; i < 6; i++) host.wr16(i[2:0], {4'h1, i[3:0], 4'h2, i[3:0]});
        host.wr(`IDX_UNIT, 8'hB5);
        for (i = 1; i < 6; i++) begin
            host.rd(i[2:0], 1'b1, rv);
            check(rv, {4'h1, i[3:0]});
            host.rd(i[2:0], 1'b0, rv);
            check(rv, {4'h2, i[3:0]});
        end
        for (i = 0; i < 5; i++) begin
            host.wr(`IDX_COMMAND, ops[i]);
            wait_for(1'b1);
            check(code, ops[i]);
            check(use_f, uses[i]);
            check(drive, 1'b1);
            check(head, i < 2 ? 4'h5 : 4'h0);
            check(feature, 16'h1121);
            if (i < 2) check({count, lba}, 64'h0022_0000_0525_2423);
            if (i == 2) check({count, lba}, 64'h1222_1514_1325_2423);
            @(negedge clk_sys_i);
            done = 1'b1;
            @(negedge clk_sys_i);
            done = 1'b0;
            wait_for(1'b0);
        end
        for (i = 0; i < 5; i++) begin
            host.wr(`IDX_COMMAND, nops[i]);
            wait_for(1'b0);
            check(error, i == 4 ? `ERR_ABORT : `ERR_NONE);
        end
        host.wr(`IDX_COMMAND, `OP_CHK_PWR_A);
        arst_n_i = 1'b0;
        @(negedge clk_sys_i);
        check({busy, irq, error}, 10'h000);
        arst_n_i = 1'b1;
        standby = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check({busy, irq, error}, 10'h000);
        // Abandoned query must not linger; a fresh one still answers
        host.wr(`IDX_COMMAND, `OP_CHK_PWR_A);
        wait_for(1'b0);
        host.rd(`IDX_COUNT, 1'b0, rv);
        check(rv, `PWR_IDLE_ANS);
        results();
    end
endmodule
